// >>> rtl/coh_pkg.sv
// Purpose: shared constants for the cache coherence operation controller
// Assumes: AXI4-Lite with 32-bit data, byte addresses in the low 8 bits
// Notes: offsets are byte addresses, one aligned word per register
package coh_pkg;
  localparam int DATA_W = 32;
  localparam int COUNT_W = 16;
  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [7:0] OFF_BAR = 8'h00;
  localparam logic [7:0] OFF_WORD_COUNT = 8'h04;
  localparam logic [7:0] OFF_BLK_SEL = 8'h08;
  localparam logic [7:0] OFF_FREEZE = 8'h0c;
  localparam logic [7:0] OFF_L1_INV_ALL = 8'h10;
  localparam logic [7:0] OFF_L1_WB_INV_ALL = 8'h14;
  localparam logic [7:0] OFF_L2_INV_ALL = 8'h18;
  localparam logic [7:0] OFF_L2_WB_INV_ALL = 8'h1c;
  localparam logic [7:0] OFF_L1_WB_ALL = 8'h20;
  localparam logic [7:0] OFF_L2_WB_ALL = 8'h24;
  localparam logic [7:0] OFF_STATUS = 8'h28;
  // ************************************************************
  // field layouts and encodings
  // ************************************************************
  localparam logic [1:0] OP_WB = 2'h0;
  localparam logic [1:0] OP_INV = 2'h1;
  localparam logic [1:0] OP_WB_INV = 2'h2;
  localparam int BLK_SEL_LEVEL_BIT = 2;
  localparam int GLOBAL_CMD_BIT = 0;
  localparam int FREEZE_BIT = 0;
  localparam logic [2:0] BLK_SEL_RESET = 3'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ************************************************************
  // cache geometry
  // ************************************************************
  localparam logic [31:0] LINE_BYTES = 32'h0000_0040;
  localparam logic [31:0] LINE_MASK = 32'hffff_ffc0;
  localparam logic [15:0] WORDS_PER_LINE = 16'h0010;
  localparam logic [15:0] L1_LINES = 16'h0200;
  localparam logic [15:0] L2_LINES = 16'h1000;
  typedef enum logic {ST_IDLE, ST_RUN} state_t;
endpackage

// >>> rtl/coh_ctrl.sv
// Purpose: block and global cache coherence sequencer with an AXI4-Lite register file
// Assumes: one 10 MHz clock, synchronous active-low reset, cache engine takes one line per handshake
// Notes: block ops walk cache lines from the base address; global ops walk every line index
// How it works
// RL1 - core allocations are held while an invalidating operation runs, keeping level-2 sets consistent.
// RL2 - base address register holds the start; writing a word count launches block operation.
// RL3 - word count reads nonzero while a block operation runs, zero once finished.
// RL4 - writing one to a global command register starts that global operation.
// RL5 - bit zero of a global command register stays set while running, clears when done.
// RL6 - a memory fence stalls the core until the coherence operation completes.
// RL7 - software idles memory, polls or fences, then runs sixteen no-ops before interrupts.
// RL8 - the idle precaution applies to all operations except the writeback-only ones.
// RL9 - software fences, freezes level-1, starts writeback-invalidate, polls, fences, unfreezes.
// RL10 - with level-1 frozen, core traffic proceeds alongside the running operation.
// RL11 - a block operation covers the lines spanning start address plus word count.
`timescale 1ns/1ps
module coh_ctrl (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [7:0] i_awaddr,
  input wire logic [2:0] i_awprot,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [7:0] i_araddr,
  input wire logic [2:0] i_arprot,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  input wire logic i_fence_req,
  output logic o_fence_stall,
  output logic o_core_hold,
  output logic o_maint_valid,
  input wire logic i_maint_ready,
  output logic [31:0] o_maint_addr,
  output logic [1:0] o_maint_op,
  output logic o_maint_level,
  output logic o_maint_global
);
  typedef struct packed {
    coh_pkg::state_t fsm;
    logic [31:0] bar;
    logic [15:0] cnt;
    logic [2:0] blk_sel;
    logic freeze;
    logic [5:0] gbusy;
    logic [15:0] lines_left;
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic maint_valid;
    logic [31:0] maint_addr;
    logic [1:0] maint_op;
    logic maint_level;
    logic maint_global;
    logic fence_stall;
    logic core_hold;
  } st_t;

  st_t s_reg;
  st_t s_next;
  logic wr_fire;
  logic rd_fire;
  logic step;
  logic [31:0] wr_val;

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic invalidates(input logic [1:0] op);
    return (op == coh_pkg::OP_INV) || (op == coh_pkg::OP_WB_INV);
  endfunction

  // lines touched by [bar, bar + 4*cnt); fits in 22 bits for any 16-bit count
  function automatic logic [15:0] span_lines(input logic [31:0] bar, input logic [15:0] cnt);
    logic [31:0] span;
    span = {26'h0, bar[5:0]} + {14'h0, cnt, 2'h0} + 32'h0000_003f;
    return span[21:6];
  endfunction

  assign wr_fire = s_reg.aw_have && s_reg.w_have && !s_reg.bvalid;
  assign rd_fire = i_arvalid && s_reg.arready;
  assign step = s_reg.maint_valid && i_maint_ready;
  assign wr_val = merge(32'h0, s_reg.w_data, s_reg.w_strb);

  // ************************************************************
  // next-state logic
  // ************************************************************
  always_comb begin
    s_next = s_reg;
    // write channels are captured independently, in either order
    if (i_awvalid && s_reg.awready) begin
      s_next.aw_have = 1'b1;
      s_next.aw_addr = i_awaddr;
      s_next.awready = 1'b0;
    end
    if (i_wvalid && s_reg.wready) begin
      s_next.w_have = 1'b1;
      s_next.w_data = i_wdata;
      s_next.w_strb = i_wstrb;
      s_next.wready = 1'b0;
    end
    if (s_reg.bvalid && i_bready) begin
      s_next.bvalid = 1'b0;
      s_next.awready = 1'b1;
      s_next.wready = 1'b1;
    end
    // line walk: valid is held until the engine takes the line
    if (step) begin
      if (s_reg.lines_left == 16'h0001) begin
        s_next.fsm = coh_pkg::ST_IDLE;
        s_next.maint_valid = 1'b0;
        s_next.gbusy = 6'h00; // [RL5]
        s_next.cnt = 16'h0000; // [RL3]
        s_next.lines_left = 16'h0000;
      end else begin
        s_next.lines_left = s_reg.lines_left - 16'h0001;
        // never reaches zero early, so polling cannot see a false finish
        s_next.cnt = (s_reg.cnt > coh_pkg::WORDS_PER_LINE) ? s_reg.cnt - coh_pkg::WORDS_PER_LINE : 16'h0001; // [RL3]
        s_next.maint_addr = s_reg.maint_addr + (s_reg.maint_global ? 32'h0000_0001 : coh_pkg::LINE_BYTES); // [RL11]
      end
    end
    // register writes; launches only from idle, a busy write is dropped except to the freeze register
    if (wr_fire) begin
      s_next.bvalid = 1'b1;
      s_next.bresp = coh_pkg::RESP_OKAY;
      s_next.aw_have = 1'b0;
      s_next.w_have = 1'b0;
      case (s_reg.aw_addr)
        coh_pkg::OFF_BAR: begin
          if (s_reg.fsm == coh_pkg::ST_IDLE) begin
            s_next.bar = merge(s_reg.bar, s_reg.w_data, s_reg.w_strb); // [RL2]
          end
        end
        coh_pkg::OFF_WORD_COUNT: begin
          if ((s_reg.fsm == coh_pkg::ST_IDLE) && (wr_val[15:0] != 16'h0000)) begin
            s_next.cnt = wr_val[15:0]; // [RL2]
            s_next.fsm = coh_pkg::ST_RUN;
            s_next.lines_left = span_lines(s_reg.bar, wr_val[15:0]); // [RL11]
            s_next.maint_valid = 1'b1;
            s_next.maint_addr = s_reg.bar & coh_pkg::LINE_MASK; // [RL11]
            s_next.maint_op = s_reg.blk_sel[1:0];
            s_next.maint_level = s_reg.blk_sel[coh_pkg::BLK_SEL_LEVEL_BIT];
            s_next.maint_global = 1'b0;
          end
        end
        coh_pkg::OFF_BLK_SEL: begin
          if (s_reg.fsm == coh_pkg::ST_IDLE) begin
            // the unused op code folds onto writeback-invalidate
            s_next.blk_sel = {wr_val[2], (wr_val[1:0] == 2'h3) ? coh_pkg::OP_WB_INV : wr_val[1:0]};
          end
        end
        coh_pkg::OFF_FREEZE: begin
          if (s_reg.w_strb[0]) begin
            s_next.freeze = s_reg.w_data[coh_pkg::FREEZE_BIT];
          end
        end
        coh_pkg::OFF_L1_INV_ALL, coh_pkg::OFF_L1_WB_INV_ALL, coh_pkg::OFF_L2_INV_ALL,
        coh_pkg::OFF_L2_WB_INV_ALL, coh_pkg::OFF_L1_WB_ALL, coh_pkg::OFF_L2_WB_ALL: begin
          if ((s_reg.fsm == coh_pkg::ST_IDLE) && wr_val[coh_pkg::GLOBAL_CMD_BIT]) begin
            s_next.fsm = coh_pkg::ST_RUN; // [RL4]
            s_next.maint_valid = 1'b1;
            s_next.maint_addr = 32'h0000_0000;
            s_next.maint_global = 1'b1;
            case (s_reg.aw_addr)
              coh_pkg::OFF_L1_INV_ALL: begin
                s_next.gbusy = 6'h01;
                s_next.maint_op = coh_pkg::OP_INV;
                s_next.maint_level = 1'b0;
              end
              coh_pkg::OFF_L1_WB_INV_ALL: begin
                s_next.gbusy = 6'h02;
                s_next.maint_op = coh_pkg::OP_WB_INV;
                s_next.maint_level = 1'b0;
              end
              coh_pkg::OFF_L2_INV_ALL: begin
                s_next.gbusy = 6'h04;
                s_next.maint_op = coh_pkg::OP_INV;
                s_next.maint_level = 1'b1;
              end
              coh_pkg::OFF_L2_WB_INV_ALL: begin
                s_next.gbusy = 6'h08;
                s_next.maint_op = coh_pkg::OP_WB_INV;
                s_next.maint_level = 1'b1;
              end
              coh_pkg::OFF_L1_WB_ALL: begin
                s_next.gbusy = 6'h10;
                s_next.maint_op = coh_pkg::OP_WB;
                s_next.maint_level = 1'b0;
              end
              default: begin
                s_next.gbusy = 6'h20;
                s_next.maint_op = coh_pkg::OP_WB;
                s_next.maint_level = 1'b1;
              end
            endcase
            s_next.lines_left = s_next.maint_level ? coh_pkg::L2_LINES : coh_pkg::L1_LINES;
          end
        end
        coh_pkg::OFF_STATUS: begin
          s_next.bresp = coh_pkg::RESP_OKAY;
        end
        default: begin
          s_next.bresp = coh_pkg::RESP_SLVERR;
        end
      endcase
    end
    // reads answer one cycle after the address is taken
    if (s_reg.rvalid && i_rready) begin
      s_next.rvalid = 1'b0;
      s_next.arready = 1'b1;
    end
    if (rd_fire) begin
      s_next.arready = 1'b0;
      s_next.rvalid = 1'b1;
      s_next.rresp = coh_pkg::RESP_OKAY;
      s_next.rdata = 32'h0000_0000;
      case (i_araddr)
        coh_pkg::OFF_BAR: s_next.rdata = s_reg.bar;
        coh_pkg::OFF_WORD_COUNT: s_next.rdata = {16'h0000, s_reg.cnt}; // [RL3] [RL9]
        coh_pkg::OFF_BLK_SEL: s_next.rdata = {29'h0, s_reg.blk_sel};
        coh_pkg::OFF_FREEZE: s_next.rdata = {31'h0, s_reg.freeze};
        coh_pkg::OFF_L1_INV_ALL: s_next.rdata = {31'h0, s_reg.gbusy[0]}; // [RL5]
        coh_pkg::OFF_L1_WB_INV_ALL: s_next.rdata = {31'h0, s_reg.gbusy[1]}; // [RL5]
        coh_pkg::OFF_L2_INV_ALL: s_next.rdata = {31'h0, s_reg.gbusy[2]}; // [RL5]
        coh_pkg::OFF_L2_WB_INV_ALL: s_next.rdata = {31'h0, s_reg.gbusy[3]}; // [RL5]
        coh_pkg::OFF_L1_WB_ALL: s_next.rdata = {31'h0, s_reg.gbusy[4]};
        coh_pkg::OFF_L2_WB_ALL: s_next.rdata = {31'h0, s_reg.gbusy[5]};
        coh_pkg::OFF_STATUS: begin
          s_next.rdata = {25'h0, s_reg.core_hold, s_reg.fence_stall, s_reg.maint_global,
                          s_reg.maint_level, s_reg.maint_op, s_reg.fsm == coh_pkg::ST_RUN};
        end
        default: s_next.rresp = coh_pkg::RESP_SLVERR;
      endcase
    end
    // fence holds the core while any maintenance is outstanding
    s_next.fence_stall = i_fence_req && (s_next.fsm == coh_pkg::ST_RUN); // [RL6]
    // writeback-only work and a frozen level-1 let core traffic run alongside
    s_next.core_hold = s_next.fsm == coh_pkg::ST_RUN && invalidates(s_next.maint_op) && !s_next.freeze; // [RL1] [RL10]
  end

  // state register
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      s_reg <= '0;
      s_reg.awready <= 1'b1;
      s_reg.wready <= 1'b1;
      s_reg.arready <= 1'b1;
      s_reg.blk_sel <= coh_pkg::BLK_SEL_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_awready = s_reg.awready;
  assign o_wready = s_reg.wready;
  assign o_bvalid = s_reg.bvalid;
  assign o_bresp = s_reg.bresp;
  assign o_arready = s_reg.arready;
  assign o_rvalid = s_reg.rvalid;
  assign o_rdata = s_reg.rdata;
  assign o_rresp = s_reg.rresp;
  assign o_fence_stall = s_reg.fence_stall;
  assign o_core_hold = s_reg.core_hold;
  assign o_maint_valid = s_reg.maint_valid;
  assign o_maint_addr = s_reg.maint_addr;
  assign o_maint_op = s_reg.maint_op;
  assign o_maint_level = s_reg.maint_level;
  assign o_maint_global = s_reg.maint_global;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);

  sequence blk_launch;
    wr_fire && (s_reg.aw_addr == coh_pkg::OFF_WORD_COUNT) && (s_reg.fsm == coh_pkg::ST_IDLE) && (wr_val[15:0] != 16'h0000);
  endsequence
  sequence glob_launch;
    wr_fire && (s_reg.aw_addr == coh_pkg::OFF_L2_INV_ALL) && (s_reg.fsm == coh_pkg::ST_IDLE) && wr_val[0];
  endsequence

  a_count_busy_nonzero: assert property ((s_reg.fsm == coh_pkg::ST_RUN) && !s_reg.maint_global // [RL3]
    |-> s_reg.cnt != 16'h0000) else $error("word count zero while block op runs");
  a_count_idle_zero: assert property ((s_reg.fsm == coh_pkg::ST_IDLE) |-> s_reg.cnt == 16'h0000) // [RL3]
    else $error("word count nonzero while idle");
  a_block_launch_addr: assert property (blk_launch |=> (s_reg.fsm == coh_pkg::ST_RUN) && o_maint_valid // [RL2]
    && (o_maint_addr == ($past(s_reg.bar) & coh_pkg::LINE_MASK)) && !o_maint_global)
    else $error("block op did not start at base line");
  a_block_span: assert property (blk_launch |=> // [RL11]
    s_reg.lines_left == span_lines($past(s_reg.bar), $past(wr_val[15:0]))) else $error("block op line count wrong");
  a_glob_start_bit: assert property (glob_launch |=> s_reg.gbusy[2] && o_maint_global // [RL4]
    && (s_reg.lines_left == coh_pkg::L2_LINES)) else $error("global command bit not set at start");
  a_glob_bit_clear: assert property ($fell(s_reg.fsm == coh_pkg::ST_RUN) // [RL5]
    |-> s_reg.gbusy == 6'h00 && !o_maint_valid) else $error("global command bit left set after finish");
  a_fence_stall_run: assert property (i_fence_req && (s_reg.fsm == coh_pkg::ST_RUN) // [RL6]
    && !(step && s_reg.lines_left == 16'h0001) |=> o_fence_stall)
    else $error("fence not stalled during operation");
  a_fence_release: assert property (o_fence_stall |-> s_reg.fsm == coh_pkg::ST_RUN) // [RL6]
    else $error("fence stalled with nothing outstanding");
  a_hold_frozen: assert property (s_reg.freeze |-> !o_core_hold) // [RL10]
    else $error("core held while level-1 frozen");
  a_hold_invalidate: assert property ((s_reg.fsm == coh_pkg::ST_RUN) && invalidates(s_reg.maint_op) // [RL1]
    && !s_reg.freeze |-> o_core_hold)
    else $error("core not held during invalidating op");
  a_line_held: assert property (o_maint_valid && !i_maint_ready |=> o_maint_valid && $stable(o_maint_addr)) // [RL11]
    else $error("line request dropped before taken");
endmodule

// >>> verification/maint_engine_model.sv
// Purpose: cache engine stand-in that takes maintenance line requests
// Assumes: one line per valid/ready handshake, ready is registered
// Notes: slow mode waits thirteen cycles before each line
`timescale 1ns/1ps
module maint_engine_model (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_clear,
  input wire logic i_slow,
  input wire logic i_valid,
  input wire logic [31:0] i_addr,
  output logic o_ready,
  output logic [15:0] o_count,
  output logic [31:0] o_first,
  output logic [31:0] o_last
);
  logic [3:0] wait_cnt;
  // ************************************************************
  // ready generation and line capture
  // ************************************************************
  // ready drops after every line, so the design must hold each request through a stall
  always_ff @(posedge i_clk) begin
    if (!i_rstn || i_clear) begin
      o_ready <= 1'b0;
      wait_cnt <= 4'h0;
      o_count <= 16'h0;
    end else if (i_valid && o_ready) begin
      o_ready <= 1'b0;
      wait_cnt <= 4'h0;
      o_count <= o_count + 16'h1;
      o_last <= i_addr;
      if (o_count == 16'h0) begin
        o_first <= i_addr;
      end
    end else if (i_valid) begin
      o_ready <= !i_slow || wait_cnt == 4'hc; // slow: about a dozen idle cycles
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule

// >>> verification/tb_coh_ctrl.sv
// Purpose: self-checking bench for the coherence operation controller
// Assumes: AXI4-Lite master driven on rising edges, handshakes judged at the falling edge before
// Notes: rows cover every global command and block launches; fence, freeze, refusals, reset follow
`timescale 1ns/1ps
module tb_coh_ctrl;
  typedef struct packed {logic [7:0] off; logic [31:0] data; logic [31:0] bar; logic [1:0] op; logic lvl;
    logic slow;} row_t;
  localparam int LIMIT = 40000;
  localparam row_t ROWS [9] = '{'{8'h10, 32'h1, 32'h0, 2'h1, 1'b0, 1'b0}, '{8'h14, 32'h1, 32'h0, 2'h2, 1'b0, 1'b0},
    '{8'h18, 32'h1, 32'h0, 2'h1, 1'b1, 1'b0}, '{8'h1c, 32'h1, 32'h0, 2'h2, 1'b1, 1'b0},
    '{8'h20, 32'h1, 32'h0, 2'h0, 1'b0, 1'b0}, '{8'h24, 32'h1, 32'h0, 2'h0, 1'b1, 1'b0},
    '{8'h04, 32'h10, 32'h1234, 2'h2, 1'b0, 1'b1}, '{8'h04, 32'h1, 32'h2000, 2'h1, 1'b1, 1'b1},
    '{8'h04, 32'h20, 32'h40, 2'h0, 1'b1, 1'b1}};
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
  logic i_fence_req = 1'b0, eng_clear = 1'b0, eng_slow = 1'b0;
  logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_fence_stall, o_core_hold, o_maint_valid, eng_ready;
  logic [1:0] o_bresp, o_rresp, o_maint_op;
  logic o_maint_level, o_maint_global;
  logic [31:0] o_rdata, o_maint_addr, eng_first, eng_last;
  logic [15:0] eng_count;
  int failures = 0, total_checks = 0, cycles = 0;

  coh_ctrl dut (.i_clk, .i_rstn, .i_awvalid, .o_awready, .i_awaddr, .i_awprot(3'h0), .i_wvalid, .o_wready,
    .i_wdata, .i_wstrb(4'hf), .o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready, .i_araddr,
    .i_arprot(3'h0), .o_rvalid, .i_rready, .o_rdata, .o_rresp, .i_fence_req, .o_fence_stall, .o_core_hold,
    .o_maint_valid, .i_maint_ready(eng_ready), .o_maint_addr, .o_maint_op, .o_maint_level,
    .o_maint_global);
  maint_engine_model eng (.i_clk, .i_rstn, .i_clear(eng_clear), .i_slow(eng_slow), .i_valid(o_maint_valid),
    .i_addr(o_maint_addr), .o_ready(eng_ready), .o_count(eng_count), .o_first(eng_first), .o_last(eng_last));

  // 10 MHz clock
  always #50 i_clk = ~i_clk;
  // hang guard, sized for the long level-2 walks
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      failures++;
      results();
    end
  end
  // ************************************************************
  // bus tasks and checks
  // ************************************************************
  // handshakes are judged at the falling edge so no decision races the design's own updates
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic ta, tw, tb;
    @(posedge i_clk);
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge i_clk);
      ta = i_awvalid && o_awready;
      tw = i_wvalid && o_wready;
      tb = o_bvalid && i_bready;
      resp = o_bresp;
      @(posedge i_clk);
      if (ta) i_awvalid <= 1'b0;
      if (tw) i_wvalid <= 1'b0;
      if (tb) i_bready <= 1'b0;
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    logic ta, tr;
    @(posedge i_clk);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      @(negedge i_clk);
      ta = i_arvalid && o_arready;
      tr = o_rvalid && i_rready;
      d = o_rdata;
      resp = o_rresp;
      @(posedge i_clk);
      if (ta) i_arvalid <= 1'b0;
      if (tr) i_rready <= 1'b0;
    end
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    logic [31:0] d, first, lines;
    logic [1:0] r;
    logic glob;
    repeat (12) @(posedge i_clk);
    i_rstn <= 1'b1;
    // one row per launch: status while running, busy readback, completion, line walk
    for (int i = 0; i < 9; i++) begin
      @(posedge i_clk);
      eng_slow <= ROWS[i].slow;
      eng_clear <= 1'b1;
      @(posedge i_clk);
      eng_clear <= 1'b0;
      glob = ROWS[i].off != coh_pkg::OFF_WORD_COUNT;
      first = glob ? 32'h0 : ROWS[i].bar & coh_pkg::LINE_MASK;
      lines = glob ? (ROWS[i].lvl ? coh_pkg::L2_LINES : coh_pkg::L1_LINES)
        : (ROWS[i].bar[5:0] + 4 * ROWS[i].data + 63) >> 6;
      if (!glob) wr(coh_pkg::OFF_BAR, ROWS[i].bar, r);
      if (!glob) wr(coh_pkg::OFF_BLK_SEL, {29'h0, ROWS[i].lvl, ROWS[i].op}, r);
      wr(ROWS[i].off, ROWS[i].data, r);
      chk(r, coh_pkg::RESP_OKAY);
      rd(coh_pkg::OFF_STATUS, d, r);
      chk(d, {25'h0, ROWS[i].op != coh_pkg::OP_WB, 1'b0, glob, ROWS[i].lvl, ROWS[i].op, 1'b1});
      chk(o_core_hold, ROWS[i].op != coh_pkg::OP_WB);
      chk({o_maint_global, o_maint_level, o_maint_op}, {glob, ROWS[i].lvl, ROWS[i].op});
      rd(ROWS[i].off, d, r);
      chk(d, ROWS[i].data);
      while ((glob ? {15'h0, d[0]} : d[15:0]) !== 16'h0) rd(ROWS[i].off, d, r);
      chk(d, 32'h0);
      chk(eng_count, lines);
      chk(eng_first, first);
      chk(eng_last, first + (glob ? 32'h1 : coh_pkg::LINE_BYTES) * (lines - 1));
      repeat (16) @(posedge i_clk);
      $display("row %0d done", i);
    end
    // fence while idle must not stall; then freeze, start, traffic, fence, unfreeze
    i_fence_req <= 1'b1;
    repeat (2) @(negedge i_clk);
    chk(o_fence_stall, 1'b0);
    @(posedge i_clk);
    i_fence_req <= 1'b0;
    eng_clear <= 1'b1;
    @(posedge i_clk);
    eng_clear <= 1'b0;
    wr(coh_pkg::OFF_FREEZE, 32'h1, r);
    wr(coh_pkg::OFF_BAR, 32'h100, r);
    wr(coh_pkg::OFF_BLK_SEL, 32'h2, r);
    wr(coh_pkg::OFF_WORD_COUNT, 32'h40, r);
    rd(coh_pkg::OFF_STATUS, d, r);
    chk(d, 32'h5);
    wr(coh_pkg::OFF_BAR, 32'h3000, r);
    i_fence_req <= 1'b1;
    repeat (3) @(negedge i_clk);
    chk(o_fence_stall, 1'b1);
    while (o_fence_stall === 1'b1) @(negedge i_clk);
    chk(eng_count, 32'h4);
    @(posedge i_clk);
    i_fence_req <= 1'b0;
    rd(coh_pkg::OFF_BAR, d, r);
    chk(d, 32'h100);
    wr(coh_pkg::OFF_FREEZE, 32'h0, r);
    $display("fence and freeze done");
    // unmapped place, zero count, command bit clear
    wr(8'h2c, 32'h1, r);
    chk(r, coh_pkg::RESP_SLVERR);
    rd(8'h2c, d, r);
    chk({d[29:0], r}, {30'h0, coh_pkg::RESP_SLVERR});
    wr(coh_pkg::OFF_WORD_COUNT, 32'h0, r);
    wr(coh_pkg::OFF_L1_INV_ALL, 32'h2, r);
    rd(coh_pkg::OFF_STATUS, d, r);
    chk(d, {29'h0, coh_pkg::OP_WB_INV, 1'b0});
    $display("refusals done");
    // reset in the middle of a long walk
    wr(coh_pkg::OFF_L2_INV_ALL, 32'h1, r);
    @(posedge i_clk);
    i_rstn <= 1'b0;
    repeat (12) @(negedge i_clk);
    chk({o_maint_valid, o_core_hold, o_awready, o_arready}, 32'h3);
    @(posedge i_clk);
    i_rstn <= 1'b1;
    rd(coh_pkg::OFF_STATUS, d, r);
    chk(d, 32'h0);
    rd(coh_pkg::OFF_BLK_SEL, d, r);
    chk(d, {29'h0, coh_pkg::BLK_SEL_RESET});
    rd(coh_pkg::OFF_WORD_COUNT, d, r);
    chk(d, 32'h0);
    $display("reset done");
    results();
  end
endmodule
